// [verilog/ceau_core.sv]
`timescale 1ns/1ps
module ceau_core
  import ceau_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic valid_i,
  input wire ceau_mode_t mode_i,
  input wire ceau_size_t size_i,
  input wire ceau_flag_op_t flag_op_i,
  input wire logic [15:0] instr_i,
  input wire logic use_imm_i,
  input wire logic [CEAU_DW-1:0] selected_general_register_i,
  input wire logic [CEAU_DW-1:0] source_register_i,
  input wire logic [CEAU_DW-1:0] zero_index_register_i,
  input wire logic [CEAU_DW-1:0] global_base_pointer_i,
  input wire logic branch_if_true_i,
  input wire logic branch_if_false_i,
  output logic mem_req_o,
  output logic [CEAU_DW-1:0] mem_addr_o,
  output logic [CEAU_DW-1:0] operand_o,
  output logic reg_wb_o,
  output logic [CEAU_DW-1:0] reg_wb_data_o,
  output logic test_flag_o,
  output logic branch_taken_o
);

  // ==========================================================================
  // Size decoding
  // ==========================================================================
  // Step for increment and decrement, same size as the scaling
  function automatic logic [CEAU_DW-1:0] ceau_step(input ceau_size_t sz);
    case (sz)
      CEAU_SZ_WORD: ceau_step = 32'h0000_0002;
      CEAU_SZ_LONG: ceau_step = 32'h0000_0004;
      default: ceau_step = 32'h0000_0001;
    endcase
  endfunction

  // Zero-extended displacement scaled by operand size
  function automatic logic [CEAU_DW-1:0] ceau_scale(input logic [7:0] d, input ceau_size_t sz);
    logic [CEAU_DW-1:0] z;
    z = {24'h00_0000, d};
    case (sz)
      CEAU_SZ_WORD: ceau_scale = {z[CEAU_DW-2:0], 1'b0};
      CEAU_SZ_LONG: ceau_scale = {z[CEAU_DW-3:0], 2'b00};
      default: ceau_scale = z;
    endcase
  endfunction

  logic [CEAU_DW-1:0] step;
  logic [CEAU_DW-1:0] addr_nxt;
  logic req_nxt;
  logic wb_nxt;
  logic [CEAU_DW-1:0] wb_data_nxt;
  logic [CEAU_DW-1:0] imm_ext;
  logic [CEAU_DW-1:0] cmp_src;
  logic test_flag_r;
  logic flag_nxt;

  assign step = ceau_step(size_i);

  // ==========================================================================
  // Immediate operand
  // ==========================================================================
  // Only an 8-bit field exists; sign-extended for compare
  assign imm_ext = {{(CEAU_DW-CEAU_IMM_W){instr_i[CEAU_IMM_LSB+CEAU_IMM_W-1]}},
                    instr_i[CEAU_IMM_LSB +: CEAU_IMM_W]};
  assign cmp_src = use_imm_i ? imm_ext : source_register_i;

  // ==========================================================================
  // Effective address generation
  // ==========================================================================
  // Address, memory request and base write-back per mode
  always_comb begin
    addr_nxt = '0;
    req_nxt = 1'b0;
    wb_nxt = 1'b0;
    wb_data_nxt = selected_general_register_i;
    case (mode_i)
      CEAU_AM_REG_DIRECT: begin
        req_nxt = 1'b0;
      end
      CEAU_AM_REG_IND: begin
        addr_nxt = selected_general_register_i;
        req_nxt = 1'b1;
      end
      CEAU_AM_POST_INC: begin
        addr_nxt = selected_general_register_i;
        req_nxt = 1'b1;
        wb_nxt = 1'b1;
        wb_data_nxt = selected_general_register_i + step;
      end
      CEAU_AM_PRE_DEC: begin
        addr_nxt = selected_general_register_i - step;
        req_nxt = 1'b1;
        wb_nxt = 1'b1;
        wb_data_nxt = selected_general_register_i - step;
      end
      CEAU_AM_REG_DISP: begin
        addr_nxt = selected_general_register_i
                   + ceau_scale({4'h0, instr_i[CEAU_DISP4_W-1:0]}, size_i);
        req_nxt = 1'b1;
      end
      CEAU_AM_INDEXED: begin
        addr_nxt = selected_general_register_i + zero_index_register_i;
        req_nxt = 1'b1;
      end
      CEAU_AM_GLOBAL_DISP: begin
        addr_nxt = global_base_pointer_i
                   + ceau_scale(instr_i[CEAU_DISP8_W-1:0], size_i);
        req_nxt = 1'b1;
      end
      default: begin
        req_nxt = 1'b0;
      end
    endcase
  end

  // Registered address-side outputs
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      mem_req_o <= 1'b0;
      mem_addr_o <= '0;
      operand_o <= '0;
      reg_wb_o <= 1'b0;
      reg_wb_data_o <= '0;
    end else begin
      mem_req_o <= valid_i && req_nxt;
      mem_addr_o <= addr_nxt;
      operand_o <= selected_general_register_i;
      reg_wb_o <= valid_i && wb_nxt;
      reg_wb_data_o <= wb_data_nxt;
    end
  end

  // ==========================================================================
  // Test flag
  // ==========================================================================
  // Next flag value; only compares change it
  always_comb begin
    flag_nxt = test_flag_r;
    case (flag_op_i)
      CEAU_FOP_COMPARE_EQUAL: flag_nxt = (selected_general_register_i == cmp_src);
      CEAU_FOP_COMPARE_SIGNED_GE: flag_nxt = ($signed(selected_general_register_i)
                                   >= $signed(cmp_src));
      CEAU_FOP_ADD: flag_nxt = test_flag_r;
      default: flag_nxt = test_flag_r;
    endcase
  end

  // Status register test bit
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      test_flag_r <= CEAU_FLAG_RST;
    end else if (valid_i) begin
      test_flag_r <= flag_nxt;
    end
  end

  assign test_flag_o = test_flag_r;

  // ==========================================================================
  // Branch resolution
  // ==========================================================================
  // Decided on the stored flag only
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      branch_taken_o <= 1'b0;
    end else begin
      branch_taken_o <= valid_i && ((branch_if_true_i && test_flag_r)
                        || (branch_if_false_i && !test_flag_r));
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  AST_GE: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    valid_i && flag_op_i == CEAU_FOP_COMPARE_SIGNED_GE |=>
      test_flag_o == ($signed($past(selected_general_register_i)) >= $signed($past(cmp_src))))
    else $error("ge compare flag wrong");
  AST_EQ: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    valid_i && flag_op_i == CEAU_FOP_COMPARE_EQUAL |=>
      test_flag_o == ($past(selected_general_register_i) == $past(cmp_src)))
    else $error("eq compare flag wrong");
  AST_BT: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    valid_i && branch_if_true_i && !branch_if_false_i |=> branch_taken_o == $past(test_flag_o))
    else $error("branch if true wrong");
  AST_BF: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    valid_i && branch_if_false_i && !branch_if_true_i |=> branch_taken_o != $past(test_flag_o))
    else $error("branch if false wrong");
  AST_ADD: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    flag_op_i inside {CEAU_FOP_ADD, CEAU_FOP_NONE} |=> $stable(test_flag_o))
    else $error("flag changed without compare");
  AST_DIRECT: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    valid_i && mode_i == CEAU_AM_REG_DIRECT |=> !mem_req_o && !reg_wb_o)
    else $error("direct mode made access");
  AST_IND: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    valid_i && mode_i == CEAU_AM_REG_IND |=>
      mem_req_o && !reg_wb_o && mem_addr_o == $past(selected_general_register_i))
    else $error("indirect address wrong");
  AST_POST: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    valid_i && mode_i == CEAU_AM_POST_INC && size_i == CEAU_SZ_LONG |=>
      reg_wb_o && reg_wb_data_o == mem_addr_o + 32'h0000_0004)
    else $error("post increment wrong");
  AST_PRE: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    valid_i && mode_i == CEAU_AM_PRE_DEC && size_i == CEAU_SZ_WORD |=>
      reg_wb_o && reg_wb_data_o == mem_addr_o
      && mem_addr_o == $past(selected_general_register_i) - 32'h0000_0002)
    else $error("pre decrement wrong");
  AST_DISP4: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    valid_i && mode_i == CEAU_AM_REG_DISP && size_i == CEAU_SZ_LONG |=>
      mem_addr_o == $past(selected_general_register_i) + {26'h0, $past(instr_i[3:0]), 2'b00})
    else $error("register displacement wrong");
  AST_INDEX: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    valid_i && mode_i == CEAU_AM_INDEXED |=>
      mem_addr_o == $past(selected_general_register_i) + $past(zero_index_register_i))
    else $error("indexed address wrong");
  AST_GDISP: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    valid_i && mode_i == CEAU_AM_GLOBAL_DISP && size_i == CEAU_SZ_WORD |=>
      mem_addr_o == $past(global_base_pointer_i) + {23'h0, $past(instr_i[7:0]), 1'b0})
    else $error("global displacement wrong");

  // Idle cycles: no pulses and the flag holds
  AST_IDLE: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    !valid_i |=> !mem_req_o && !reg_wb_o && !branch_taken_o && $stable(test_flag_o))
    else $error("idle cycle changed outputs");
  // Register direct passes the register through as operand
  AST_OPERAND: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    valid_i && mode_i == CEAU_AM_REG_DIRECT |=>
      operand_o == $past(selected_general_register_i))
    else $error("direct operand wrong");
  // Both branch kinds at once, and no branch at all
  AST_BOTH: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    valid_i && branch_if_true_i && branch_if_false_i |=> branch_taken_o)
    else $error("double branch not taken");
  AST_NOBR: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    valid_i && !branch_if_true_i && !branch_if_false_i |=> !branch_taken_o)
    else $error("branch taken without request");
  // Remaining sizes of each update and displacement mode
  AST_POST_B: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    valid_i && mode_i == CEAU_AM_POST_INC && size_i == CEAU_SZ_BYTE |=>
      reg_wb_o && mem_addr_o == $past(selected_general_register_i)
      && reg_wb_data_o == $past(selected_general_register_i) + 32'h0000_0001)
    else $error("byte post increment wrong");
  AST_POST_W: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    valid_i && mode_i == CEAU_AM_POST_INC && size_i == CEAU_SZ_WORD |=>
      reg_wb_o && mem_addr_o == $past(selected_general_register_i)
      && reg_wb_data_o == $past(selected_general_register_i) + 32'h0000_0002)
    else $error("word post increment wrong");
  AST_PRE_B: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    valid_i && mode_i == CEAU_AM_PRE_DEC && size_i == CEAU_SZ_BYTE |=>
      reg_wb_o && mem_req_o && reg_wb_data_o == mem_addr_o
      && mem_addr_o == $past(selected_general_register_i) - 32'h0000_0001)
    else $error("byte pre decrement wrong");
  AST_PRE_L: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    valid_i && mode_i == CEAU_AM_PRE_DEC && size_i == CEAU_SZ_LONG |=>
      reg_wb_o && mem_req_o && reg_wb_data_o == mem_addr_o
      && mem_addr_o == $past(selected_general_register_i) - 32'h0000_0004)
    else $error("longword pre decrement wrong");
  AST_DISP4_B: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    valid_i && mode_i == CEAU_AM_REG_DISP && size_i == CEAU_SZ_BYTE |=>
      mem_addr_o == $past(selected_general_register_i) + {28'h0, $past(instr_i[3:0])})
    else $error("byte register displacement wrong");
  AST_DISP4_W: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    valid_i && mode_i == CEAU_AM_REG_DISP && size_i == CEAU_SZ_WORD |=>
      mem_addr_o == $past(selected_general_register_i) + {27'h0, $past(instr_i[3:0]), 1'b0})
    else $error("word register displacement wrong");
  AST_GDISP_B: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    valid_i && mode_i == CEAU_AM_GLOBAL_DISP && size_i == CEAU_SZ_BYTE |=>
      mem_addr_o == $past(global_base_pointer_i) + {24'h0, $past(instr_i[7:0])})
    else $error("byte global displacement wrong");
  AST_GDISP_L: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    valid_i && mode_i == CEAU_AM_GLOBAL_DISP && size_i == CEAU_SZ_LONG |=>
      mem_addr_o == $past(global_base_pointer_i) + {22'h0, $past(instr_i[7:0]), 2'b00})
    else $error("longword global displacement wrong");

  COV_GE_BT: cover property (@(posedge clk_sys_i) disable iff (reset_i)
    valid_i && flag_op_i == CEAU_FOP_COMPARE_SIGNED_GE ##1 valid_i && branch_if_true_i ##1 branch_taken_o);
  COV_EQ_BF: cover property (@(posedge clk_sys_i) disable iff (reset_i)
    valid_i && flag_op_i == CEAU_FOP_COMPARE_EQUAL ##1 valid_i && branch_if_false_i ##1 branch_taken_o);
  COV_POST: cover property (@(posedge clk_sys_i) disable iff (reset_i)
    valid_i && mode_i == CEAU_AM_POST_INC ##1 reg_wb_o);
  COV_GDISP: cover property (@(posedge clk_sys_i) disable iff (reset_i)
    valid_i && mode_i == CEAU_AM_GLOBAL_DISP ##1 mem_req_o);

endmodule

// [verilog/ceau_pkg.sv]
package ceau_pkg;

  // ==========================================================================
  // Operand sizes
  // ==========================================================================
  typedef enum logic [1:0] {
    CEAU_SZ_BYTE = 2'h0,
    CEAU_SZ_WORD = 2'h1,
    CEAU_SZ_LONG = 2'h2
  } ceau_size_t;

  // ==========================================================================
  // Addressing modes
  // ==========================================================================
  typedef enum logic [2:0] {
    CEAU_AM_REG_DIRECT = 3'h0,
    CEAU_AM_REG_IND = 3'h1,
    CEAU_AM_POST_INC = 3'h2,
    CEAU_AM_PRE_DEC = 3'h3,
    CEAU_AM_REG_DISP = 3'h4,
    CEAU_AM_INDEXED = 3'h5,
    CEAU_AM_GLOBAL_DISP = 3'h6
  } ceau_mode_t;

  // ==========================================================================
  // Flag operations
  // ==========================================================================
  typedef enum logic [2:0] {
    CEAU_FOP_NONE = 3'h0,
    CEAU_FOP_COMPARE_EQUAL = 3'h1,
    CEAU_FOP_COMPARE_SIGNED_GE = 3'h2,
    CEAU_FOP_ADD = 3'h3
  } ceau_flag_op_t;

  // ==========================================================================
  // Widths, field positions and reset values
  // ==========================================================================
  localparam int CEAU_DW = 32;
  localparam int CEAU_IMM_LSB = 0;
  localparam int CEAU_IMM_W = 8;
  localparam int CEAU_DISP4_W = 4;
  localparam int CEAU_DISP8_W = 8;
  localparam logic CEAU_FLAG_RST = 1'b0;

endpackage

// [test/ceau_mem_model.sv]
`timescale 1ns/1ps
// ==========================================================================
// Data memory path model: accepts every access pulse and tallies it
// ==========================================================================
module ceau_mem_model
  import ceau_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic mem_req_i,
  input wire logic [CEAU_DW-1:0] mem_addr_i,
  output logic [31:0] access_count_o,
  output logic [CEAU_DW-1:0] last_addr_o
);
  // Zero-wait memory: an access pulse is taken at the edge it is seen on
  initial begin
    access_count_o = 32'h0;
    last_addr_o = 32'h0;
    forever begin
      @(posedge clk_sys_i);
      if (mem_req_i === 1'b1) begin
        access_count_o <= access_count_o + 32'h1;
        last_addr_o <= mem_addr_i;
      end
    end
  end
endmodule

// [test/cpu_effective_address_unit_tb_top.sv]
`timescale 1ns/1ps
module cpu_effective_address_unit_tb_top;
  import ceau_pkg::*;
  logic clk_sys_i = 1'b0, reset_i = 1'b1, valid_i = 1'b0, use_imm_i = 1'b0;
  ceau_mode_t mode_i = CEAU_AM_REG_DIRECT;
  ceau_size_t size_i = CEAU_SZ_BYTE;
  ceau_flag_op_t flag_op_i = CEAU_FOP_NONE;
  logic [15:0] instr_i = 16'h0;
  logic [31:0] gen_reg = 32'h0, src_reg = 32'h0, idx_reg = 32'h0, gbase = 32'h0;
  logic br_true = 1'b0, br_false = 1'b0, mem_req_o, reg_wb_o, test_flag_o, branch_taken_o;
  logic [31:0] mem_addr_o, operand_o, reg_wb_data_o, acc_cnt, last_addr;
  logic [31:0] e_addr, e_wbd, stp, cmpv, tb_acc, seen_acc;
  logic [31:0] addr_q[$]; // Addresses the memory side must see, oldest first
  logic e_req, e_wb, e_op, e_br, flag;
  int miscompares = 0, num_checks = 0;
  // ==========================================================================
  // Clock and instances
  // ==========================================================================
  always #5 clk_sys_i = ~clk_sys_i;
  ceau_core dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .valid_i(valid_i), .mode_i(mode_i),
    .size_i(size_i), .flag_op_i(flag_op_i), .instr_i(instr_i), .use_imm_i(use_imm_i),
    .selected_general_register_i(gen_reg), .source_register_i(src_reg),
    .zero_index_register_i(idx_reg), .global_base_pointer_i(gbase),
    .branch_if_true_i(br_true), .branch_if_false_i(br_false), .mem_req_o(mem_req_o),
    .mem_addr_o(mem_addr_o), .operand_o(operand_o), .reg_wb_o(reg_wb_o),
    .reg_wb_data_o(reg_wb_data_o), .test_flag_o(test_flag_o), .branch_taken_o(branch_taken_o));
  ceau_mem_model mem (.clk_sys_i(clk_sys_i), .mem_req_i(mem_req_o), .mem_addr_i(mem_addr_o),
    .access_count_o(acc_cnt), .last_addr_o(last_addr));
  // ==========================================================================
  // Checking and reference model
  // ==========================================================================
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Predict from inputs set at this falling edge, then check after the next edge
  task automatic go();
    stp = (size_i == CEAU_SZ_BYTE) ? 32'h1 : (size_i == CEAU_SZ_WORD) ? 32'h2 : 32'h4;
    cmpv = use_imm_i ? {{24{instr_i[7]}}, instr_i[7:0]} : src_reg;
    e_req = valid_i && (3'(mode_i) inside {[3'h1 : 3'h6]}); // Mode 7 makes no access
    e_wb = valid_i && (mode_i == CEAU_AM_POST_INC || mode_i == CEAU_AM_PRE_DEC);
    e_op = valid_i && mode_i == CEAU_AM_REG_DIRECT;
    e_wbd = (mode_i == CEAU_AM_POST_INC) ? gen_reg + stp : gen_reg - stp;
    case (mode_i)
      CEAU_AM_PRE_DEC: e_addr = gen_reg - stp;
      CEAU_AM_REG_DISP: e_addr = gen_reg + {28'h0, instr_i[3:0]} * stp;
      CEAU_AM_INDEXED: e_addr = gen_reg + idx_reg;
      CEAU_AM_GLOBAL_DISP: e_addr = gbase + {24'h0, instr_i[7:0]} * stp;
      default: e_addr = gen_reg;
    endcase
    e_br = valid_i && ((br_true && flag) || (br_false && !flag));
    if (valid_i && flag_op_i == CEAU_FOP_COMPARE_EQUAL) flag = (gen_reg == cmpv);
    if (valid_i && flag_op_i == CEAU_FOP_COMPARE_SIGNED_GE) flag = ($signed(gen_reg) >= $signed(cmpv));
    if (reset_i) {e_req, e_wb, e_br, flag} = 4'h0;
    if (e_req) begin
      tb_acc = tb_acc + 32'h1;
      addr_q.push_back(e_addr);
    end
    @(negedge clk_sys_i);
    chk(mem_req_o, e_req, "access pulse");
    if (e_req) chk(mem_addr_o, e_addr, "address");
    chk(reg_wb_o, e_wb, "writeback pulse");
    if (e_wb) chk(reg_wb_data_o, e_wbd, "writeback value");
    if (e_op && !reset_i) chk(operand_o, gen_reg, "operand");
    chk(test_flag_o, flag, "test flag");
    chk(branch_taken_o, e_br, "branch");
    // The memory side takes a pulse one edge after it appears
    if (acc_cnt !== seen_acc) begin
      seen_acc = acc_cnt;
      if (addr_q.size() == 0) chk(32'h1, 32'h0, "unexpected access");
      else chk(last_addr, addr_q.pop_front(), "memory address");
    end
  endtask
  // Register-direct compare or branch with the given operands
  task automatic put(input ceau_flag_op_t f, input logic [31:0] a, input logic [31:0] s,
                     input logic ui, input logic [7:0] im, input logic tk, input logic fk);
    valid_i = 1'b1;
    mode_i = CEAU_AM_REG_DIRECT;
    flag_op_i = f;
    gen_reg = a;
    src_reg = s;
    use_imm_i = ui;
    instr_i = {8'h00, im};
    br_true = tk;
    br_false = fk;
    go();
  endtask
  task automatic finish_test();
    chk(acc_cnt, tb_acc, "access count");
    chk(addr_q.size(), 32'h0, "accesses not seen");
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ==========================================================================
  // Main sequence: reset, compare/branch walk, random traffic, mid-run reset
  // ==========================================================================
  initial begin
    flag = 1'b0;
    tb_acc = 32'h0;
    seen_acc = 32'h0;
    void'($urandom(32'h8632));
    repeat (3) @(negedge clk_sys_i);
    reset_i = 1'b0;
    put(CEAU_FOP_COMPARE_SIGNED_GE, 32'h5, 32'h3, 1'b0, 8'h00, 1'b0, 1'b0);
    put(CEAU_FOP_NONE, 32'h0, 32'h0, 1'b0, 8'h00, 1'b1, 1'b0);
    put(CEAU_FOP_ADD, 32'h7, 32'h9, 1'b0, 8'h00, 1'b0, 1'b1);
    put(CEAU_FOP_COMPARE_SIGNED_GE, 32'hffffffff, 32'h1, 1'b0, 8'h00, 1'b0, 1'b1);
    put(CEAU_FOP_COMPARE_EQUAL, 32'h0, 32'h5, 1'b1, 8'h00, 1'b0, 1'b0);
    put(CEAU_FOP_NONE, 32'h0, 32'h0, 1'b0, 8'h00, 1'b1, 1'b0);
    put(CEAU_FOP_COMPARE_EQUAL, 32'hffffffff, 32'h0, 1'b1, 8'hff, 1'b1, 1'b1);
    put(CEAU_FOP_COMPARE_SIGNED_GE, 32'h80000000, 32'h80000000, 1'b0, 8'h00, 1'b0, 1'b0);
    for (int i = 0; i < 800; i++) begin
      valid_i = ($urandom_range(0, 9) != 0);
      mode_i = ceau_mode_t'(3'($urandom_range(0, 7)));
      size_i = ceau_size_t'(2'($urandom_range(0, 2)));
      flag_op_i = ceau_flag_op_t'(3'($urandom_range(0, 3)));
      instr_i = 16'($urandom);
      use_imm_i = 1'($urandom);
      gen_reg = $urandom;
      src_reg = $urandom_range(0, 1) ? gen_reg : $urandom;
      idx_reg = $urandom;
      gbase = $urandom;
      {br_true, br_false} = 2'($urandom);
      reset_i = (i == 500);
      go();
    end
    reset_i = 1'b0;
    valid_i = 1'b0;
    go();
    finish_test();
  end
endmodule
